// ---- ips_core_model.sv ----
// far-side model: peripheral request sources and the core's view of the outputs
`timescale 1ns/1ps
`default_nettype none
module ips_core_model (
    input  wire logic                            clock_i,
    input  wire logic                            high_req_i,
    input  wire logic                            low_req_i,
    output var  logic [ips_pkg::NUM_SOURCES-1:0] source_req_o
);
    // levels the core saw on the previous edge
    logic [1:0] level_seen;

    // sources start idle
    initial source_req_o = 9'h000;

    // core side samples both request levels each edge
    always_ff @(posedge clock_i) begin
        level_seen <= {high_req_i, low_req_i};
    end

    // request levels change just after a rising edge
    task automatic set_sources(input logic [ips_pkg::NUM_SOURCES-1:0] v);
        @(posedge clock_i);
        source_req_o <= v;
    endtask : set_sources
endmodule : ips_core_model
`default_nettype wire

// ---- ips_interrupt_priority_select.sv ----
// priority select register bank with axi4-lite slave and request routing
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - second register bits 7,6,3,2 give osc, comparator, collision, voltage priority.
// - second register bits 1,0 set timer3 and capture2 priority; writable, reset one.
// - third register bits 5,4 set serial receive/transmit priority; read-only, reset zero.
// - third register bit 0 sets capture3 priority; writable, resets to one.
// - unused bits of all three registers always read as zero.
// - priority levels enable is reset-cause bit 7, writable, resets zero.
// - with enable clear, single level: no high/low distinction.
// - reset-cause flags keep their documented access and reset values.
// - per-source priority bits act only while levels enable is set.
module ips_interrupt_priority_select #(
    parameter int ADDR_W = 5
) (
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic                          rst_unused_none_i,
    input  wire logic [ips_pkg::NUM_SOURCES-1:0] source_req_i,
    output logic                   high_req_o,
    output logic                   low_req_o,
    output logic                   priority_levels_enable_o,
    output logic                   irq_o
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (ADDR_W < 5) begin : g_bad_addr
        $error("address width too small for the register map");
    end

    ips_pkg::ips_state_t st;
    ips_pkg::ips_state_t next_st;

    logic [ips_pkg::NUM_SOURCES-1:0] prio_vec;
    logic [4:0]                      rd_addr;
    logic [31:0]                     wr_mask;

    // ****************************************
    // per-source priority vector
    // ****************************************
    assign prio_vec = {st.prio_third[ips_pkg::BIT_CAPTURE3_PRIORITY],
                       st.prio_third[ips_pkg::BIT_SERIAL2_TRANSMIT_PRIORITY],
                       st.prio_third[ips_pkg::BIT_SERIAL2_RECEIVE_PRIORITY],
                       st.prio_second[ips_pkg::BIT_CAPTURE2_PRIORITY],
                       st.prio_second[ips_pkg::BIT_TIMER3_OVERFLOW_PRIORITY],
                       st.prio_second[ips_pkg::BIT_VOLTAGE_DETECT_PRIORITY],
                       st.prio_second[ips_pkg::BIT_BUS_COLLISION_PRIORITY],
                       st.prio_second[ips_pkg::BIT_COMPARATOR_PRIORITY],
                       st.prio_second[ips_pkg::BIT_OSC_FAIL_PRIORITY]};

    // byte strobes widened to a bit mask
    assign wr_mask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    assign rd_addr = s_axi_araddr_i[4:0];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [ips_pkg::NUM_SOURCES-1:0] rise;
        logic [ips_pkg::NUM_SOURCES-1:0] clr;
        logic [7:0]                      wm;
        logic                            priority_levels_enable;
        rise = '0;
        clr  = '0;
        wm   = '0;
        priority_levels_enable = 1'b0;
        next_st = st;
        // address and data are taken in either order
        if (s_axi_awvalid_i && st.awready) begin
            next_st.aw_ok  = 1'b1;
            next_st.awaddr = s_axi_awaddr_i[4:0];
        end
        if (s_axi_wvalid_i && st.wready) begin
            next_st.w_ok  = 1'b1;
            next_st.wdata = s_axi_wdata_i;
            next_st.wstrb = s_axi_wstrb_i;
        end
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        // register write once both halves are held
        if (st.aw_ok && st.w_ok && !st.bvalid) begin
            next_st.aw_ok  = 1'b0;
            next_st.w_ok   = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = ips_pkg::RESP_OKAY;
            unique case (st.awaddr)
                ips_pkg::OFS_PRIO_SECOND: begin
                    wm = ips_pkg::WR_PRIO_SECOND & wr_mask[7:0];
                    next_st.prio_second = (st.prio_second & ~wm) | (st.wdata[7:0] & wm);
                end
                ips_pkg::OFS_PRIO_THIRD: begin
                    wm = ips_pkg::WR_PRIO_THIRD & wr_mask[7:0];
                    next_st.prio_third = (st.prio_third & ~wm) | (st.wdata[7:0] & wm);
                end
                ips_pkg::OFS_RESET_CAUSE: begin
                    wm = ips_pkg::WR_RESET_CAUSE & wr_mask[7:0];
                    next_st.reset_cause = (st.reset_cause & ~wm) | (st.wdata[7:0] & wm);
                end
                ips_pkg::OFS_IRQ_STATUS: begin
                    clr = st.wdata[ips_pkg::NUM_SOURCES-1:0]
                        & wr_mask[ips_pkg::NUM_SOURCES-1:0];
                end
                ips_pkg::OFS_IRQ_MASK: begin
                    next_st.mask = (st.mask & ~wr_mask[ips_pkg::NUM_SOURCES-1:0])
                                 | (st.wdata[ips_pkg::NUM_SOURCES-1:0]
                                    & wr_mask[ips_pkg::NUM_SOURCES-1:0]);
                end
                default: begin
                    next_st.bresp = ips_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_st.awready = !next_st.aw_ok && !next_st.bvalid;
        next_st.wready  = !next_st.w_ok && !next_st.bvalid;
        // read channel
        if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = ips_pkg::RESP_OKAY;
            next_st.rdata  = '0;
            unique case (rd_addr)
                ips_pkg::OFS_PRIO_SECOND: begin
                    next_st.rdata[7:0] = st.prio_second & ips_pkg::IMP_PRIO_SECOND;
                end
                ips_pkg::OFS_PRIO_THIRD: begin
                    next_st.rdata[7:0] = st.prio_third & ips_pkg::IMP_PRIO_THIRD;
                end
                ips_pkg::OFS_RESET_CAUSE: begin
                    next_st.rdata[7:0] = st.reset_cause & ips_pkg::IMP_RESET_CAUSE;
                end
                ips_pkg::OFS_IRQ_STATUS: begin
                    next_st.rdata[ips_pkg::NUM_SOURCES-1:0] = st.status;
                end
                ips_pkg::OFS_IRQ_MASK: begin
                    next_st.rdata[ips_pkg::NUM_SOURCES-1:0] = st.mask;
                end
                default: begin
                    next_st.rresp = ips_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_st.arready = !next_st.rvalid;
        // sticky events, a new event beats a clear
        rise = source_req_i & ~st.req_q;
        next_st.req_q  = source_req_i;
        next_st.status = (st.status & ~clr) | rise;
        next_st.irq    = |(next_st.status & next_st.mask);
        // routing of the live source request levels to the two request outputs
        priority_levels_enable = st.reset_cause[ips_pkg::BIT_PRIORITY_LEVELS_ENABLE];
        if (priority_levels_enable) begin
            next_st.high_req = |(source_req_i & prio_vec);
            next_st.low_req  = |(source_req_i & ~prio_vec);
        end else begin
            next_st.high_req = |source_req_i;
            next_st.low_req  = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st             <= '0;
            st.awready     <= 1'b1;
            st.wready      <= 1'b1;
            st.arready     <= 1'b1;
            st.prio_second <= ips_pkg::RST_PRIO_SECOND;
            st.prio_third  <= ips_pkg::RST_PRIO_THIRD;
            st.reset_cause <= ips_pkg::RST_RESET_CAUSE;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready_o          = st.awready;
    assign s_axi_wready_o           = st.wready;
    assign s_axi_bvalid_o           = st.bvalid;
    assign s_axi_bresp_o            = st.bresp;
    assign s_axi_arready_o          = st.arready;
    assign s_axi_rvalid_o           = st.rvalid;
    assign s_axi_rdata_o            = st.rdata;
    assign s_axi_rresp_o            = st.rresp;
    assign high_req_o               = st.high_req;
    assign low_req_o                = st.low_req;
    assign irq_o                    = st.irq;
    assign priority_levels_enable_o = st.reset_cause[ips_pkg::BIT_PRIORITY_LEVELS_ENABLE];

    // ****************************************
    // assertions
    // ****************************************
    sequence aw_take_s;
        s_axi_awvalid_i && s_axi_awready_o;
    endsequence

    sequence w_take_s;
        s_axi_wvalid_i && s_axi_wready_o;
    endsequence

    sequence wr_prio_second_s;
        aw_take_s and w_take_s ##0 (s_axi_awaddr_i[4:0] == ips_pkg::OFS_PRIO_SECOND)
            ##0 s_axi_wstrb_i[0];
    endsequence

    write_second_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wr_prio_second_s |-> ##2 (st.prio_second == ($past(s_axi_wdata_i[7:0], 2)
                                  & ips_pkg::WR_PRIO_SECOND)))
        else $error("second priority register write not applied");

    write_resp_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (aw_take_s and w_take_s) |-> ##2 s_axi_bvalid_o)
        else $error("write response late");

    third_ro_bits_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        st.prio_third[5:4] == 2'h0)
        else $error("read-only serial priority bits changed");

    unused_read_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[4:0] == ips_pkg::OFS_PRIO_THIRD)
        |=> (s_axi_rvalid_o && s_axi_rdata_o[7:6] == 2'h0 && s_axi_rdata_o[3:1] == 3'h0))
        else $error("unused bits of third register read nonzero");

    flags_ro_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        st.reset_cause[3:2] == 2'h3)
        else $error("read-only reset-cause flags changed");

    single_level_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (!priority_levels_enable_o && |source_req_i) |=> (high_req_o && !low_req_o))
        else $error("single level mode not applied");

    low_route_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (priority_levels_enable_o && |(source_req_i & ~prio_vec)) |=> low_req_o)
        else $error("low priority source not routed low");

    high_route_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (priority_levels_enable_o && (source_req_i & prio_vec) == '0) |=> !high_req_o)
        else $error("high output raised with no high source");

    priority_levels_enable_reset_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> !priority_levels_enable_o)
        else $error("levels enable not clear after reset");

    sticky_irq_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        irq_o == |(st.status & st.mask))
        else $error("interrupt output disagrees with status and mask");

    read_answer_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (s_axi_arvalid_i && s_axi_arready_o) |=> s_axi_rvalid_o)
        else $error("read answer late");

    sequence wr_prio_third_s;
        aw_take_s and w_take_s ##0 (s_axi_awaddr_i[4:0] == ips_pkg::OFS_PRIO_THIRD)
            ##0 s_axi_wstrb_i[0];
    endsequence

    sequence wr_reset_cause_s;
        aw_take_s and w_take_s ##0 (s_axi_awaddr_i[4:0] == ips_pkg::OFS_RESET_CAUSE)
            ##0 s_axi_wstrb_i[0];
    endsequence

    // only the capture3 bit of the third register takes a write
    third_write_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wr_prio_third_s |-> ##2 (st.prio_third == ($past(s_axi_wdata_i[7:0], 2)
                                 & ips_pkg::WR_PRIO_THIRD)))
        else $error("third priority register write not applied");

    // writable reset-cause bits follow the data, read-only flags keep their value
    cause_write_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wr_reset_cause_s |-> ##2 (st.reset_cause == (($past(st.reset_cause, 2)
                                  & ~ips_pkg::WR_RESET_CAUSE)
                                  | ($past(s_axi_wdata_i[7:0], 2) & ips_pkg::WR_RESET_CAUSE))))
        else $error("reset-cause register write not applied");

    // all three registers leave reset at their documented values
    reset_values_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> (st.prio_second == ips_pkg::RST_PRIO_SECOND
                            && st.prio_third == ips_pkg::RST_PRIO_THIRD
                            && st.reset_cause == ips_pkg::RST_RESET_CAUSE))
        else $error("registers not at reset values after reset");

    // each rising source leaves its status bit set, even against a clear
    for (genvar i = 0; i < ips_pkg::NUM_SOURCES; i++) begin : g_sticky
        status_set_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
            (source_req_i[i] && !st.req_q[i]) |=> st.status[i])
            else $error("rising source did not set its status bit");
    end

endmodule : ips_interrupt_priority_select
`default_nettype wire

// ---- ips_interrupt_priority_select_tb_top.sv ----
// bench for the priority select block: bus tasks, reset values, routing, interrupt
`timescale 1ns/1ps
`default_nettype none
module ips_interrupt_priority_select_tb_top;
    logic        clock_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, high, low, en, irq;
    logic [1:0]  bresp, rresp, rsp;
    logic [8:0]  src;
    int          n_mismatch = 0;
    int          comparisons = 0;

    // ****************************************
    // design and far-side model
    // ****************************************
    ips_interrupt_priority_select DUT (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rst_unused_none_i(1'b0),
        .source_req_i(src), .high_req_o(high), .low_req_o(low),
        .priority_levels_enable_o(en), .irq_o(irq));
    ips_core_model core (.clock_i(clock_i), .high_req_i(high), .low_req_i(low),
        .source_req_o(src));

    // 50 MHz clock
    initial begin
        forever #10 clock_i = ~clock_i;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic hang(input string what);
        n_mismatch++;
        $display("mismatch at %0t: no answer to %s", $time, what);
        close_out();
    endtask : hang

    // write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clock_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clock_i);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang("write");
    endtask : axi_wr

    // read: rready held until rvalid is sampled
    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clock_i);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang("read");
    endtask : axi_rd

    task automatic wr_ok(input logic [4:0] a, input logic [31:0] d);
        axi_wr(a, d, rsp);
        chk({30'h0, rsp}, 32'h0, "write response");
    endtask : wr_ok

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        axi_rd(a, rd, rsp);
        chk({30'h0, rsp}, 32'h0, "read response");
        chk(rd, exp, "read data");
    endtask : rd_chk

    // raise each source alone and compare the chosen request output
    task automatic route_chk(input logic [7:0] s, input logic [7:0] t, input logic e);
        logic [8:0] pv;
        pv = {t[0], t[4], t[5], s[0], s[1], s[2], s[3], s[6], s[7]};
        for (int i = 0; i < 9; i++) begin
            core.set_sources(9'h001 << i);
            @(posedge clock_i);
            @(negedge clock_i);
            chk({30'h0, high, low}, e ? {30'h0, pv[i], ~pv[i]} : 32'h2, "request route");
            core.set_sources(9'h000);
        end
    endtask : route_chk

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd_chk(5'h00, 32'h000000CF);
        rd_chk(5'h04, 32'h00000001);
        rd_chk(5'h08, 32'h0000005C);
        chk({31'h0, en}, 32'h0, "levels enable at reset");
        route_chk(8'hCF, 8'h01, 1'b0);
        wr_ok(5'h00, 32'h000000FF);
        rd_chk(5'h00, 32'h000000CF);
        wr_ok(5'h04, 32'h000000FF);
        rd_chk(5'h04, 32'h00000001);
        wr_ok(5'h08, 32'h000000FF);
        rd_chk(5'h08, 32'h000000DF);
        chk({31'h0, en}, 32'h1, "levels enable set");
        route_chk(8'hCF, 8'h01, 1'b1);
        wr_ok(5'h00, 32'h00000000);
        rd_chk(5'h00, 32'h00000000);
        wr_ok(5'h04, 32'h00000000);
        rd_chk(5'h04, 32'h00000000);
        route_chk(8'h00, 8'h00, 1'b1);
        wr_ok(5'h08, 32'h00000000);
        rd_chk(5'h08, 32'h0000000C);
        route_chk(8'h00, 8'h00, 1'b0);
        // unmapped place answers with an error and zero data
        axi_wr(5'h14, 32'hFFFFFFFF, rsp);
        chk({30'h0, rsp}, 32'h2, "unmapped write");
        axi_rd(5'h14, rd, rsp);
        chk({22'h0, rsp, rd[7:0]}, 32'h200, "unmapped read");
        // every source has risen once, mask still clear
        rd_chk(5'h0C, 32'h000001FF);
        chk({31'h0, irq}, 32'h0, "masked interrupt");
        wr_ok(5'h10, 32'h00000008);
        @(negedge clock_i);
        chk({31'h0, irq}, 32'h1, "unmasked interrupt");
        wr_ok(5'h0C, 32'h000001FF);
        @(negedge clock_i);
        rd_chk(5'h0C, 32'h00000000);
        chk({31'h0, irq}, 32'h0, "cleared interrupt");
        core.set_sources(9'h008);
        repeat (2) @(negedge clock_i);
        chk({31'h0, irq}, 32'h1, "new event");
        core.set_sources(9'h000);
        // reset in mid-run brings the enable back to its reset value
        wr_ok(5'h08, 32'h00000080);
        @(posedge clock_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd_chk(5'h08, 32'h0000005C);
        rd_chk(5'h10, 32'h00000000);
        close_out();
    end
endmodule : ips_interrupt_priority_select_tb_top
`default_nettype wire

// ---- ips_pkg.sv ----
// constants and types for the interrupt priority select block
package ips_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [4:0] OFS_PRIO_SECOND = 5'h00;
    localparam logic [4:0] OFS_PRIO_THIRD  = 5'h04;
    localparam logic [4:0] OFS_RESET_CAUSE = 5'h08;
    localparam logic [4:0] OFS_IRQ_STATUS  = 5'h0C;
    localparam logic [4:0] OFS_IRQ_MASK    = 5'h10;

    // ****************************************
    // reset values and bit masks
    // ****************************************
    localparam logic [7:0] RST_PRIO_SECOND = 8'hCF;
    localparam logic [7:0] RST_PRIO_THIRD  = 8'h01;
    localparam logic [7:0] RST_RESET_CAUSE = 8'h5C;
    localparam logic [7:0] WR_PRIO_SECOND  = 8'hCF;
    localparam logic [7:0] WR_PRIO_THIRD   = 8'h01;
    localparam logic [7:0] WR_RESET_CAUSE  = 8'hD3;
    localparam logic [7:0] IMP_PRIO_SECOND = 8'hCF;
    localparam logic [7:0] IMP_PRIO_THIRD  = 8'h31;
    localparam logic [7:0] IMP_RESET_CAUSE = 8'hDF;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_OSC_FAIL_PRIORITY       = 7;
    localparam int BIT_COMPARATOR_PRIORITY     = 6;
    localparam int BIT_BUS_COLLISION_PRIORITY  = 3;
    localparam int BIT_VOLTAGE_DETECT_PRIORITY = 2;
    localparam int BIT_TIMER3_OVERFLOW_PRIORITY = 1;
    localparam int BIT_CAPTURE2_PRIORITY       = 0;
    localparam int BIT_SERIAL2_RECEIVE_PRIORITY  = 5;
    localparam int BIT_SERIAL2_TRANSMIT_PRIORITY = 4;
    localparam int BIT_CAPTURE3_PRIORITY       = 0;
    localparam int BIT_PRIORITY_LEVELS_ENABLE  = 7;

    // ****************************************
    // sources and bus answers
    // ****************************************
    localparam int         NUM_SOURCES = 9;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // whole state of the block
    typedef struct packed {
        logic                   aw_ok;
        logic                   w_ok;
        logic [4:0]             awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [7:0]             prio_second;
        logic [7:0]             prio_third;
        logic [7:0]             reset_cause;
        logic [NUM_SOURCES-1:0] status;
        logic [NUM_SOURCES-1:0] mask;
        logic [NUM_SOURCES-1:0] req_q;
        logic                   high_req;
        logic                   low_req;
        logic                   irq;
    } ips_state_t;

endpackage : ips_pkg
